// >>> verification/scg_top_asserts.sv
// Checker of bus handshake, halt states and clock output relations
// Assumes: bound to scg_top, one clock domain
`timescale 1ns/1ps
module scg_top_asserts (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       halt_exec,
  input wire logic       halt_release,
  input wire logic       port_dir_bit,
  input wire logic       port_func_bit,
  input wire logic       clock_out_pin,
  input wire logic       clock_out_oe,
  input wire logic       system_clock_en,
  input wire logic       cpu_run,
  input wire logic       high_osc_run,
  input wire logic       low_osc_run,
  input wire logic       rtc_run,
  input wire logic       port_hold,
  input wire logic [1:0] halt_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Sequences
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_stop2;
    halt_state == 2'h1 ##1 halt_state == 2'h1;
  endsequence
  // ==========================================
  // Assertions
  AST_ACK: assert property (s_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  AST_OE: assert property (!$past(sys_rst) |-> clock_out_oe == $past(port_dir_bit & port_func_bit))
    else $error("clock output enable wrong");
  AST_PIN_HOLD: assert property (s_stop2 |-> $stable(clock_out_pin))
    else $error("clock output moves in stop");
  AST_OSC_RTC_CLK: assert property (halt_state == 2'h2 && $past(halt_state) == 2'h2 |-> !system_clock_en)
    else $error("system clock runs in oscillator and clock only halt");
  AST_STOP_ALL: assert property (halt_state == 2'h1 |-> !(cpu_run || rtc_run))
    else $error("activity in stop");
  AST_STOP_OSC: assert property (s_stop2 |-> !(high_osc_run || low_osc_run))
    else $error("oscillator runs in stop");
  AST_CPU_ONLY: assert property (halt_state == 2'h3 |-> !cpu_run && rtc_run)
    else $error("cpu only halt run state wrong");
  AST_NO_HALT: assert property (halt_state == 2'h0 && !halt_exec |=> halt_state == 2'h0)
    else $error("halt without instruction");
  AST_RELEASE: assert property (halt_state != 2'h0 && halt_release |=> halt_state == 2'h0 && cpu_run)
    else $error("halt not released");
  AST_PORT_HOLD: assert property (halt_state[1] |-> port_hold)
    else $error("ports not held in halt");
endmodule
bind scg_top scg_top_asserts scg_top_asserts_i (.sys_clk, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .halt_exec, .halt_release, .port_dir_bit, .port_func_bit, .clock_out_pin, .clock_out_oe, .system_clock_en,
  .cpu_run, .high_osc_run, .low_osc_run, .rtc_run, .port_hold, .halt_state);

// >>> verification/scg_top_bench.sv
// Self-checking bench for the clock gear standby controller
// Assumes: scg_top with short warm-up counts, bench makes low oscillator ticks
`timescale 1ns/1ps
module scg_top_bench;
  logic        sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, low_osc_tick = 0;
  logic        port_dir_bit = 0, port_func_bit = 0, halt_exec = 0, halt_release = 0, pin_d = 0;
  logic [9:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [11:0] cpu_halt_run_en = 12'ha5c;
  logic [1:0]  tdiv = 0;
  logic [7:0]  rd, v;
  wire  [31:0] avs_readdata;
  wire  [11:0] periph_run;
  wire  [1:0]  halt_state;
  wire         avs_waitrequest, system_clock_en, gear_clock_en, prescaler_clock_en, clock_out_pin;
  wire         clock_out_oe, high_osc_run, low_osc_run, cpu_run, rtc_run, port_hold;
  wire  [3:0]  mons = {clock_out_pin ^ pin_d, prescaler_clock_en, system_clock_en, gear_clock_en};
  int          cyc = 0, n_mismatch = 0, checks_done = 0, t0;
  int          wc[4] = '{16, 4, 8, 12};
  scg_top #(.WUP_CNT_00(16), .WUP_CNT_01(4), .WUP_CNT_10(8), .WUP_CNT_11(12)) scg_top_i (.sys_clk, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .low_osc_tick,
    .port_dir_bit, .port_func_bit, .halt_exec, .halt_release, .cpu_halt_run_en, .system_clock_en, .gear_clock_en,
    .prescaler_clock_en, .clock_out_pin, .clock_out_oe, .high_osc_run, .low_osc_run, .cpu_run, .rtc_run,
    .port_hold, .periph_run, .halt_state);
  // ==========================================
  // Clock, low oscillator ticks, timeout
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tdiv <= tdiv + 2'd1;
    low_osc_tick <= (tdiv == 2'd3);
    pin_d <= clock_out_pin;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("Error at %0t: timeout", $time);
      n_mismatch++;
      give_verdict;
    end
  end
  // ==========================================
  // Tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
    chk(n < 50, 1);
  endtask
  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    acc(0, idx, 8'h00);
    chk(rd, exp);
  endtask
  task wup_wait;
    int n;
    n = 0;
    do begin
      acc(0, 8'he0, 8'h00);
      n++;
    end while (rd[2] !== 1'b0 && n < 100);
    chk(rd[2], 0);
  endtask
  task per(input int s, input int exp);
    int n;
    n = 0;
    do @(negedge sys_clk); while (mons[s] !== 1'b1 && ++n < 200);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (mons[s] !== 1'b1 && n < 200);
    chk(16'(n), 16'(exp));
  endtask
  task pulse(input logic rel);
    @(posedge sys_clk);
    if (rel) halt_release <= 1;
    else halt_exec <= 1;
    @(posedge sys_clk);
    halt_release <= 0;
    halt_exec <= 0;
    @(negedge sys_clk);
  endtask
  task give_verdict;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 0;
    rchk(8'he0, 8'h80);
    rchk(8'he1, 8'h00);
    rchk(8'he2, 8'h2c);
    rchk(8'he3, 8'h23);
    rchk(8'he4, 8'h00);
    rchk(8'h10, 8'h00);
    for (int w = 0; w < 4; w++) begin
      acc(1, 8'he2, 8'h0c | 8'(w << 4));
      acc(1, 8'he0, 8'hc4);
      t0 = cyc;
      rchk(8'he0, 8'hc4);
      wup_wait;
      chk((cyc - t0) >= wc[w] * 4 - 4 && (cyc - t0) <= wc[w] * 4 + 8, 1);
    end
    acc(1, 8'he1, 8'h04);
    per(0, 1);
    wup_wait;
    per(0, 16);
    for (int g = 0; g < 4; g++) begin
      acc(1, 8'he1, 8'(g));
      acc(1, 8'h10, 8'h00);
      wup_wait;
      per(0, 1 << g);
    end
    acc(1, 8'he0, 8'h80);
    per(2, 16);
    acc(1, 8'he0, 8'h82);
    per(2, 64);
    acc(1, 8'he0, 8'hc4);
    wup_wait;
    acc(1, 8'he1, 8'h0b);
    per(1, 4);
    acc(1, 8'he2, 8'h1c);
    per(3, 4);
    acc(1, 8'he0, 8'h40);
    repeat (2) @(negedge sys_clk);
    chk({high_osc_run, low_osc_run}, 2'b01);
    acc(1, 8'he2, 8'h2c);
    acc(1, 8'he0, 8'hc4);
    wup_wait;
    acc(1, 8'he1, 8'h03);
    acc(1, 8'he0, 8'h80);
    per(1, 8);
    acc(1, 8'he2, 8'h4c);
    per(3, 8);
    acc(1, 8'he4, 8'h00);
    rchk(8'he3, 8'ha3);
    for (int i = 0; i < 3; i++) begin
      acc(0, 8'he0 + 8'(i), 8'h00);
      v = rd;
      acc(1, 8'he0 + 8'(i), ~v & 8'hfb);
      rchk(8'he0 + 8'(i), v);
    end
    acc(1, 8'he4, 8'h1f);
    rchk(8'he3, 8'h23);
    for (int m = 0; m < 4; m++) begin
      acc(1, 8'he2, 8'h10 | 8'(m << 2));
      pulse(0);
      chk(halt_state, 16'(m));
      chk({cpu_run, rtc_run}, m == 0 ? 2'b11 : m == 1 ? 2'b00 : 2'b01);
      chk(port_hold, m > 1);
      if (m == 3) chk(periph_run, cpu_halt_run_en);
      @(negedge sys_clk);
      chk(high_osc_run, m != 1);
      pulse(1);
      chk(halt_state, 0);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {port_dir_bit, port_func_bit} <= 2'(i);
      repeat (3) @(negedge sys_clk);
      chk(clock_out_oe, i == 3);
    end
    give_verdict;
  end
endmodule

// >>> verilog/scg_divider.v
// Enable divider: one output pulse per div input pulses
// Assumes: div is at least 1 and stable between pulses
`timescale 1ns/1ps
module scg_divider #(
  parameter W = 7
) (
  input  wire         sys_clk,
  input  wire         sys_rst,
  input  wire         tick_in,
  input  wire [W-1:0] div,
  output reg          tick_out
);
  reg [W-1:0] count;

  // ==========================================
  // Counter
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count    <= {W{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count >= div - {{(W-1){1'b0}}, 1'b1}) begin
          count    <= {W{1'b0}};
          tick_out <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// >>> verilog/scg_map.vh
// Register map, field positions, reset values and warm-up figures
// Assumes: included by the clock gear standby controller files only
`ifndef SCG_MAP_VH
`define SCG_MAP_VH

// ==========================================
// Register indices (byte address is four times the index)
`define SCG_IDX_CTRL_A        8'he0
`define SCG_IDX_CTRL_B        8'he1
`define SCG_IDX_CTRL_C        8'he2
`define SCG_IDX_PROT_STATUS   8'he3
`define SCG_IDX_PROT_KEY      8'he4

// ==========================================
// Field positions
`define SCG_A_HIGH_OSC_EN     7
`define SCG_A_LOW_OSC_EN      6
`define SCG_A_WARMUP          2
`define SCG_A_PRESCALER_SEL   1
`define SCG_B_SOURCE_SEL      3
`define SCG_C_CLKOUT_SEL      6
`define SCG_C_WARMUP_HI       5
`define SCG_C_WARMUP_LO       4
`define SCG_C_HALT_HI         3
`define SCG_C_HALT_LO         2
`define SCG_S_PROTECT         7

// ==========================================
// Reset values and codes
`define SCG_RST_CTRL_A        8'h80
`define SCG_RST_CTRL_B        8'h00
`define SCG_RST_CTRL_C        8'h2c
`define SCG_RST_PROT_LOW      7'h23
`define SCG_KEY_OPEN          8'h1f
`define SCG_HALT_RESERVED     2'h0
`define SCG_HALT_STOP         2'h1
`define SCG_HALT_OSC_RTC      2'h2
`define SCG_HALT_CPU_ONLY     2'h3
`define SCG_PRE_DIV_LOW       7'h02
`define SCG_PRE_DIV_HIGH      7'h40

// ==========================================
// Warm-up counts in oscillator cycles
`define SCG_WUP_CNT_00        262144
`define SCG_WUP_CNT_01        256
`define SCG_WUP_CNT_10        16384
`define SCG_WUP_CNT_11        65536

`endif

// >>> verilog/scg_top.v
// System clock source, gear, clock output, write protection and halt control
// Assumes: sys_clk is the high oscillator; low_osc_tick marks low oscillator cycles
//
// How it works
// - Source select 0 takes high oscillator, 1 takes low oscillator as system clock.
// - Warm-up select picks 2^8, 2^14, 2^16 or 2^18 oscillator cycles.
// - Halt mode code 00 reserved, 01 stop, 10 oscillator-clock halt, 11 CPU-only halt.
// - Writing 1 to warm-up bit restarts counter; bit reads 1 while counting.
// - High source gives gear clock of oscillator divided by 1, 2, 4, 8, 16.
// - A new gear takes effect only after a warm-up interval ends.
// - Clock output drives the pin only when port direction and function bits set.
// - Clock output select 1 gives system clock, 0 gives low clock.
// - Prescaler input is gear clock over 2 or oscillator over 64.
// - Any key other than 1f turns protection on, blocking control writes.
// - Key 1f turns protection off, control registers writable again.
// - The key register is always writable.
// - Protection flag reads in status bit 7, read only, 0 after reset.
// - Halt entry goes to CPU-only halt, oscillator-clock halt or stop per halt mode field.
// - CPU-only halt stops the CPU while oscillators and system clock run.
// - In CPU-only halt each peripheral runs only if its own run-enable bit is set.
// - Oscillator-clock halt keeps oscillator and real-time clock, stops the system clock.
// - Stop halts everything including the oscillators.
// - In both halts other than stop, port outputs keep their state.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "scg_map.vh"
module scg_top #(
  parameter NPER       = 12,
  parameter WUP_CNT_00 = `SCG_WUP_CNT_00,
  parameter WUP_CNT_01 = `SCG_WUP_CNT_01,
  parameter WUP_CNT_10 = `SCG_WUP_CNT_10,
  parameter WUP_CNT_11 = `SCG_WUP_CNT_11
) (
  input  wire            sys_clk,
  input  wire            sys_rst,
  input  wire [9:0]      avs_address,
  input  wire            avs_read,
  input  wire            avs_write,
  input  wire [31:0]     avs_writedata,
  output reg  [31:0]     avs_readdata,
  output reg             avs_waitrequest,
  input  wire            low_osc_tick,
  input  wire            port_dir_bit,
  input  wire            port_func_bit,
  input  wire            halt_exec,
  input  wire            halt_release,
  input  wire [NPER-1:0] cpu_halt_run_en,
  output reg             system_clock_en,
  output reg             gear_clock_en,
  output reg             prescaler_clock_en,
  output reg             clock_out_pin,
  output reg             clock_out_oe,
  output reg             high_osc_run,
  output reg             low_osc_run,
  output reg             cpu_run,
  output reg             rtc_run,
  output reg             port_hold,
  output reg  [NPER-1:0] periph_run,
  output reg  [1:0]      halt_state
);
  localparam ST_RUN      = 2'h0;
  localparam ST_STOP     = 2'h1;
  localparam ST_OSC_RTC  = 2'h2;
  localparam ST_CPU_ONLY = 2'h3;

  reg  [7:0]  ctrl_a;
  reg  [7:0]  ctrl_b;
  reg  [7:0]  ctrl_c;
  reg  [6:0]  prot_low;
  reg         protect;
  reg  [2:0]  gear_active;
  reg         gear_pending;
  reg  [1:0]  next_halt;
  reg  [31:0] next_readdata;
  reg  [4:0]  gear_div;
  reg  [19:0] wup_target;

  wire [7:0]  idx = avs_address[9:2];
  wire        wr_acc = avs_write && !avs_waitrequest;
  wire        wr_ok = wr_acc && !protect;
  wire [7:0]  wd = avs_writedata[7:0];
  wire        wup_busy;
  wire        wup_done;
  wire        gear_tick;
  wire        pre_tick;
  wire        wup_start;
  wire        wup_osc_tick;
  wire        high_live;
  wire        low_live;
  wire        sys_live;
  wire        next_sys;
  wire        next_gear;
  wire        out_tick;

  // ==========================================
  // Avalon slave handshake: one wait cycle per access
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // ==========================================
  // Read mux
  always @* begin
    next_readdata = 32'h0000_0000;
    case (idx)
      `SCG_IDX_CTRL_A: begin
        next_readdata[7:0] = ctrl_a;
        next_readdata[`SCG_A_WARMUP] = wup_busy;
      end
      `SCG_IDX_CTRL_B: next_readdata[7:0] = ctrl_b;
      `SCG_IDX_CTRL_C: next_readdata[7:0] = ctrl_c;
      `SCG_IDX_PROT_STATUS: next_readdata[7:0] = {protect, prot_low};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Registers and write protection
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_a       <= `SCG_RST_CTRL_A;
      ctrl_b       <= `SCG_RST_CTRL_B;
      ctrl_c       <= `SCG_RST_CTRL_C;
      prot_low     <= `SCG_RST_PROT_LOW;
      protect      <= 1'b0;
      gear_active  <= 3'h0;
      gear_pending <= 1'b0;
    end else begin
      if (wr_acc && idx == `SCG_IDX_PROT_KEY) begin
        protect <= (wd != `SCG_KEY_OPEN);
      end
      if (wr_acc && idx == `SCG_IDX_PROT_STATUS) begin
        prot_low <= wd[6:0];
      end
      // Writes with protection on fall through unchanged, no error
      if (wr_ok && idx == `SCG_IDX_CTRL_A) begin
        ctrl_a <= {wd[7:3], 1'b0, wd[1:0]};
      end
      if (wr_ok && idx == `SCG_IDX_CTRL_B) begin
        ctrl_b <= wd;
        if (wd[2:0] != ctrl_b[2:0]) begin
          gear_pending <= 1'b1;
        end
      end
      if (wr_ok && idx == `SCG_IDX_CTRL_C) begin
        ctrl_c <= wd;
      end
      if (gear_pending && wup_done && !wup_start) begin
        gear_active  <= ctrl_b[2:0];
        gear_pending <= 1'b0;
      end
    end
  end

  // ==========================================
  // Warm-up timer
  assign wup_start = (wr_ok && idx == `SCG_IDX_CTRL_A && wd[`SCG_A_WARMUP]) ||
                     (wr_ok && idx == `SCG_IDX_CTRL_B && wd[2:0] != ctrl_b[2:0]);

  always @* begin
    case (ctrl_c[`SCG_C_WARMUP_HI:`SCG_C_WARMUP_LO])
      2'h0: wup_target = WUP_CNT_00[19:0];
      2'h1: wup_target = WUP_CNT_01[19:0];
      2'h2: wup_target = WUP_CNT_10[19:0];
      2'h3: wup_target = WUP_CNT_11[19:0];
      default: wup_target = WUP_CNT_00[19:0];
    endcase
  end

  // Counts the oscillator not feeding the system clock, or the high one for a gear change
  assign wup_osc_tick = (ctrl_b[`SCG_B_SOURCE_SEL] || gear_pending) ? high_live : (low_live && low_osc_tick);

  scg_warmup #(
    .W (20)
  ) u_warmup (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .start    (wup_start),
    .osc_tick (wup_osc_tick),
    .target   (wup_target),
    .busy     (wup_busy),
    .done     (wup_done)
  );

  // ==========================================
  // Gear and prescaler dividers
  always @* begin
    case (gear_active)
      3'h0: gear_div = 5'h01;
      3'h1: gear_div = 5'h02;
      3'h2: gear_div = 5'h04;
      3'h3: gear_div = 5'h08;
      3'h4: gear_div = 5'h10;
      default: gear_div = 5'h10;
    endcase
  end

  assign high_live = ctrl_a[`SCG_A_HIGH_OSC_EN] && (halt_state != ST_STOP);
  assign low_live  = ctrl_a[`SCG_A_LOW_OSC_EN] && (halt_state != ST_STOP);

  scg_divider #(
    .W (5)
  ) u_gear_div (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .tick_in  (high_live),
    .div      (gear_div),
    .tick_out (gear_tick)
  );

  scg_divider #(
    .W (7)
  ) u_pre_div (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .tick_in  (ctrl_a[`SCG_A_PRESCALER_SEL] ? high_live : next_gear),
    .div      (ctrl_a[`SCG_A_PRESCALER_SEL] ? `SCG_PRE_DIV_HIGH : `SCG_PRE_DIV_LOW),
    .tick_out (pre_tick)
  );

  // ==========================================
  // System clock and clock output
  assign sys_live  = (halt_state == ST_RUN) || (halt_state == ST_CPU_ONLY);
  assign next_gear = gear_tick && !ctrl_b[`SCG_B_SOURCE_SEL] && sys_live;
  assign next_sys  = sys_live && (ctrl_b[`SCG_B_SOURCE_SEL] ? (low_live && low_osc_tick) : next_gear);
  assign out_tick  = ctrl_c[`SCG_C_CLKOUT_SEL] ? next_sys : (low_live && low_osc_tick);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      system_clock_en    <= 1'b0;
      gear_clock_en      <= 1'b0;
      prescaler_clock_en <= 1'b0;
      clock_out_pin      <= 1'b0;
      clock_out_oe       <= 1'b0;
      high_osc_run       <= 1'b1;
      low_osc_run        <= 1'b0;
    end else begin
      system_clock_en    <= next_sys;
      gear_clock_en      <= next_gear;
      prescaler_clock_en <= pre_tick;
      clock_out_oe       <= port_dir_bit && port_func_bit;
      if (out_tick) begin
        clock_out_pin <= ~clock_out_pin;
      end
      high_osc_run <= high_live;
      low_osc_run  <= low_live;
    end
  end

  // ==========================================
  // Halt state machine
  always @* begin
    next_halt = halt_state;
    case (halt_state)
      ST_RUN: begin
        if (halt_exec) begin
          case (ctrl_c[`SCG_C_HALT_HI:`SCG_C_HALT_LO])
            `SCG_HALT_STOP:     next_halt = ST_STOP;
            `SCG_HALT_OSC_RTC:  next_halt = ST_OSC_RTC;
            `SCG_HALT_CPU_ONLY: next_halt = ST_CPU_ONLY;
            default:            next_halt = ST_RUN;
          endcase
        end
      end
      ST_STOP, ST_OSC_RTC, ST_CPU_ONLY: begin
        if (halt_release) begin
          next_halt = ST_RUN;
        end
      end
      default: next_halt = ST_RUN;
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      halt_state <= ST_RUN;
      cpu_run    <= 1'b1;
      rtc_run    <= 1'b1;
      port_hold  <= 1'b0;
      periph_run <= {NPER{1'b1}};
    end else begin
      halt_state <= next_halt;
      cpu_run    <= (next_halt == ST_RUN);
      rtc_run    <= (next_halt != ST_STOP);
      port_hold  <= (next_halt == ST_OSC_RTC) || (next_halt == ST_CPU_ONLY);
      case (next_halt)
        ST_RUN:      periph_run <= {NPER{1'b1}};
        ST_CPU_ONLY: periph_run <= cpu_halt_run_en;
        default:     periph_run <= {NPER{1'b0}};
      endcase
    end
  end
endmodule

// >>> verilog/scg_warmup.v
// Warm-up timer counting pulses of the oscillator being started
// Assumes: start is a one-cycle pulse; target is held while busy
`timescale 1ns/1ps
module scg_warmup #(
  parameter W = 20
) (
  input  wire         sys_clk,
  input  wire         sys_rst,
  input  wire         start,
  input  wire         osc_tick,
  input  wire [W-1:0] target,
  output reg          busy,
  output reg          done
);
  reg [W-1:0] count;

  // ==========================================
  // Counter
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= {W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= {W{1'b0}};
        busy  <= 1'b1;
      end else if (busy && osc_tick) begin
        if (count >= target - {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
